// file: src/dac_cmd_decoder.sv
// Serial command decoder of an eight-channel 10-bit converter with chain output and register port.
//
// What this block does
// - While frame sync is low, shift data in on each falling shift clock edge.
// - Frame sync rising before the fifteenth falling edge aborts and discards the frame.
// - Chain output stays low for fourteen falling edges, goes high on the fifteenth.
// - Next sixteen falling edges replay the first sixteen received bits on chain output.
// - The rising sync closing a valid frame executes the decoded command.
// - After reset the block runs in register-only mode.
// - Code 1000 selects register-only mode, 1001 write-through; mode persists.
// - Bit 15 low: bits 14..12 pick channel, bits 11..2 carry the value.
// - Register-only mode: channel write changes only that channel's data register.
// - Write-through mode: channel write updates data register and output code.
// - Special commands work in both modes and keep the mode.
// - Code 1010 loads masked channel outputs from their data registers.
// - Code 1011 writes channel A register and output, loads all other outputs.
// - Code 1100 writes the value into all registers and outputs.
// - Codes 1101 to 1111 power down flagged channels with three terminations.
// - Reset clears every data register and output code to zero.
`include "dac_defs.svh"
`default_nettype none
module dac_cmd_decoder #(
   parameter int CHANNELS   = 8,
   parameter int CODE_WIDTH = 10
) (
   input  wire logic                             clk,
   input  wire logic                             rst_b,
   input  wire logic                             frame_sync_b,
   input  wire logic                             shift_clk,
   input  wire logic                             serial_in,
   output var  logic                             chain_out,
   input  wire logic [7:0]                       reg_addr,
   input  wire logic [31:0]                      reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output var  logic [31:0]                      reg_rdata,
   output wire logic [CHANNELS*CODE_WIDTH-1:0]   out_codes,
   output var  logic [CHANNELS-1:0]              pd_mask,
   output var  logic [1:0]                       pd_term,
   output var  dac_pkg::op_mode_t                operating_mode
);
   import dac_pkg::*;

   logic              rst_meta_q;
   logic              rst_sync_q;
   link_if            lk ();

   frame_state_t      state_q;
   frame_state_t      state_d;
   logic [15:0]       shift_q;
   logic [4:0]        edge_q;
   logic              link_en_q;
   logic [15:0]       exec_cnt_q;
   logic [15:0]       abort_cnt_q;
   logic [CODE_WIDTH-1:0] chan_reg_q [CHANNELS];
   logic [CODE_WIDTH-1:0] chan_out_q [CHANNELS];
   logic [31:0]       rdata_d;

   // Reset release through two flip-flops.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   link_sampler u_sampler (
      .clk          (clk),
      .rst_b        (rst_sync_q),
      .frame_sync_b (frame_sync_b),
      .shift_clk    (shift_clk),
      .serial_in    (serial_in),
      .lk           (lk)
   );

   wire        in_frame_w   = (state_q == ST_SHIFT);
   wire        shift_en_w   = in_frame_w & lk.frame_low & lk.sclk_fall;
   wire        frame_end_w  = in_frame_w & lk.frame_rise;
   wire        valid_w      = (edge_q >= `EDGE_VALID);
   wire        exec_w       = frame_end_w & valid_w;
   wire        abort_w      = frame_end_w & ~valid_w;
   wire        frame_go_w   = lk.frame_fall & link_en_q;

   // Edge counter landmarks.
   wire        edge_sat_w   = (edge_q == `EDGE_SAT);
   wire        pre_mark_w   = (edge_q < `EDGE_MARK - 5'h01);
   wire        at_mark_w    = (edge_q == `EDGE_MARK - 5'h01);


   wire [3:0]  code_w       = shift_q[`CMD_CODE_HI:`CMD_CODE_LO];
   wire [2:0]  chan_w       = shift_q[`CMD_CHAN_HI:`CMD_CHAN_LO];
   wire [CODE_WIDTH-1:0] data_w = shift_q[`CMD_DATA_HI:`CMD_DATA_LO];
   wire [7:0]  mask_w       = shift_q[`CMD_MASK_HI:`CMD_MASK_LO];

   wire        is_chan_w    = exec_w & ~shift_q[`CMD_CODE_HI];
   wire        is_mreg_w    = exec_w & (code_w == `CMD_MODE_REG);
   wire        is_mwt_w     = exec_w & (code_w == `CMD_MODE_WT);
   wire        is_upd_w     = exec_w & (code_w == `CMD_UPD_SEL);
   wire        is_chaw_w    = exec_w & (code_w == `CMD_CHA_WRITE);
   wire        is_bcast_w   = exec_w & (code_w == `CMD_BROADCAST);
   wire        is_pd_w      = exec_w & (code_w >= `CMD_PD_HIZ);
   wire        wt_w         = (operating_mode == WRITE_THROUGH_MODE);

   wire [1:0]  term_w       = (code_w == `CMD_PD_HIZ)  ? `TERM_HIZ :
                              (code_w == `CMD_PD_100K) ? `TERM_100K : `TERM_2K5;

   wire [5:0]  widx_w       = reg_addr[7:2];
   wire [2:0]  wch_w        = 3'(widx_w - `WORD_IDX_DATA);
   wire        hit_ctrl_w   = (reg_addr == `CTRL_OFF);
   wire        hit_stat_w   = (reg_addr == `STATUS_OFF);
   wire        hit_exec_w   = (reg_addr == `EXEC_CNT_OFF);
   wire        hit_abort_w  = (reg_addr == `ABORT_CNT_OFF);
   wire        hit_data_w   = (reg_addr[1:0] == 2'h0) && (widx_w >= `WORD_IDX_DATA)
                              && (widx_w < `WORD_IDX_DATA + 6'h08);
   wire        hit_out_w    = (reg_addr[1:0] == 2'h0) && (widx_w >= `WORD_IDX_OUT)
                              && (widx_w < `WORD_IDX_OUT + 6'h08);
   wire [2:0]  och_w        = 3'(widx_w - `WORD_IDX_OUT);

   // Frame sequencer.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (frame_go_w) begin
               state_d = ST_SHIFT;
            end else if (lk.frame_fall) begin
               state_d = ST_HOLD;
            end
         end
         ST_SHIFT: begin
            if (lk.frame_rise) begin
               state_d = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (lk.frame_rise) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Shift register, newest bit at the bottom.
   // Most significant bit ends at the top.
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         shift_q <= 16'h0000;
      end else if (shift_en_w) begin
         shift_q <= {shift_q[14:0], lk.data_bit};
      end
   end

   // Edge counter, restarted by each falling sync and saturated above the marker edge.
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         edge_q <= 5'h00;
      end else if (lk.frame_fall) begin
         edge_q <= 5'h00;
      end else if (shift_en_w && !edge_sat_w) begin
         edge_q <= edge_q + 5'h01;
      end
   end

   // Low for fourteen edges, high on the fifteenth.
   // Then replay bits delayed by fifteen edges.
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         chain_out <= 1'b0;
      end else if (!in_frame_w) begin
         chain_out <= 1'b0;
      end else if (shift_en_w) begin
         if (pre_mark_w) begin
            chain_out <= 1'b0;
         end else if (at_mark_w) begin
            chain_out <= 1'b1;
         end else begin
            chain_out <= shift_q[`CHAIN_TAP];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         operating_mode <= REGISTER_ONLY_MODE;
      end else if (is_mreg_w) begin
         operating_mode <= REGISTER_ONLY_MODE;
      end else if (is_mwt_w) begin
         operating_mode <= WRITE_THROUGH_MODE;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pd_term <= 2'h0;
      end else if (is_pd_w) begin
         pd_term <= term_w;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         wire sel_w     = is_chan_w & (chan_w == 3'(ch));
         wire a_new_w   = is_chaw_w & (ch == 0);

         wire bcast_w   = is_bcast_w;
         wire reg_ld_w  = sel_w | a_new_w | bcast_w;

         wire wt_ld_w   = sel_w & wt_w;
         wire mask_ld_w = is_upd_w & mask_w[ch];
         wire all_ld_w  = is_chaw_w | bcast_w;
         wire out_ld_w  = wt_ld_w | all_ld_w | mask_ld_w;
         wire out_new_w = wt_ld_w | bcast_w | a_new_w;

         always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               chan_reg_q[ch] <= '0;
            end else if (reg_ld_w) begin
               chan_reg_q[ch] <= data_w;
            end
         end

         always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               chan_out_q[ch] <= '0;
            end else if (out_ld_w) begin
               chan_out_q[ch] <= out_new_w ? data_w : chan_reg_q[ch];
            end
         end

         // Flagged channels power down; an output load wakes the channel.
         always_ff @(posedge clk or negedge rst_sync_q) begin
            if (!rst_sync_q) begin
               pd_mask[ch] <= 1'b0;
            end else if (is_pd_w && mask_w[ch]) begin
               pd_mask[ch] <= 1'b1;
            end else if (out_ld_w) begin
               pd_mask[ch] <= 1'b0;
            end
         end

         assign out_codes[ch*CODE_WIDTH +: CODE_WIDTH] = chan_out_q[ch];
      end
   endgenerate

   // Link enable register.
   wire        ctrl_wr_w    = reg_wr & hit_ctrl_w;
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         link_en_q <= `CTRL_RESET;
      end else if (ctrl_wr_w) begin
         link_en_q <= reg_wdata[0];
      end
   end

   // Frame counter increments.
   wire [15:0] exec_inc_w   = {15'h0000, exec_w};
   wire [15:0] abort_inc_w  = {15'h0000, abort_w};

   // Executed frames, wrapping.
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         exec_cnt_q <= 16'h0000;
      end else begin
         exec_cnt_q <= exec_cnt_q + exec_inc_w;
      end
   end

   // Aborted frames, wrapping.
   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         abort_cnt_q <= 16'h0000;
      end else begin
         abort_cnt_q <= abort_cnt_q + abort_inc_w;
      end
   end

   // Read selection; unmapped addresses read zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_ctrl_w) begin
         rdata_d[0] = link_en_q;
      end else if (hit_stat_w) begin
         rdata_d[0]     = operating_mode;
         rdata_d[1]     = in_frame_w;
         rdata_d[3:2]   = pd_term;
         rdata_d[15:8]  = pd_mask;
      end else if (hit_exec_w) begin
         rdata_d[15:0] = exec_cnt_q;
      end else if (hit_abort_w) begin
         rdata_d[15:0] = abort_cnt_q;
      end else if (hit_data_w) begin
         rdata_d[CODE_WIDTH-1:0] = chan_reg_q[wch_w];
      end else if (hit_out_w) begin
         rdata_d[CODE_WIDTH-1:0] = chan_out_q[och_w];
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// file: src/dac_defs.svh
// Offsets, field positions, command codes, reset values and counts of the serial command decoder.
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH

`define CTRL_OFF        8'h00
`define STATUS_OFF      8'h04
`define EXEC_CNT_OFF    8'h08
`define ABORT_CNT_OFF   8'h0C
`define DATA_BASE_OFF   8'h10
`define OUT_BASE_OFF    8'h30
`define WORD_IDX_DATA   6'h04
`define WORD_IDX_OUT    6'h0C

`define CTRL_RESET      1'h1
`define PIN_IDLE        3'h3

`define CMD_CODE_HI     15
`define CMD_CODE_LO     12
`define CMD_CHAN_HI     14
`define CMD_CHAN_LO     12
`define CMD_DATA_HI     11
`define CMD_DATA_LO     2
`define CMD_MASK_HI     7
`define CMD_MASK_LO     0

`define CMD_MODE_REG    4'h8
`define CMD_MODE_WT     4'h9
`define CMD_UPD_SEL     4'hA
`define CMD_CHA_WRITE   4'hB
`define CMD_BROADCAST   4'hC
`define CMD_PD_HIZ      4'hD
`define CMD_PD_100K     4'hE
`define CMD_PD_2K5      4'hF

`define TERM_HIZ        2'h1
`define TERM_100K       2'h2
`define TERM_2K5        2'h3

`define EDGE_VALID      5'h0F
`define EDGE_MARK       5'h0F
`define EDGE_SAT        5'h10
`define CHAIN_TAP       14

`endif

// file: src/dac_pkg.sv
// Types shared by the serial command decoder.
`default_nettype none
package dac_pkg;
   typedef enum logic {
      REGISTER_ONLY_MODE = 1'b0,
      WRITE_THROUGH_MODE = 1'b1
   } op_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_HOLD  = 2'b10
   } frame_state_t;
endpackage
`default_nettype wire

// file: src/link_if.sv
// Sampled link events passed from the pin sampler to the decoder.
`default_nettype none
interface link_if;
   logic sclk_fall;
   logic frame_fall;
   logic frame_rise;
   logic frame_low;
   logic data_bit;

   modport sampler (output sclk_fall, output frame_fall, output frame_rise, output frame_low, output data_bit);
   modport decoder (input sclk_fall, input frame_fall, input frame_rise, input frame_low, input data_bit);
endinterface
`default_nettype wire

// file: src/link_sampler.sv
// Pin synchroniser for frame sync, shift clock and serial data; edge finder for frame sync and shift clock.
`include "dac_defs.svh"
`default_nettype none
module link_sampler (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic frame_sync_b,
   input  wire logic shift_clk,
   input  wire logic serial_in,
   link_if.sampler   lk
);
   wire  [2:0] pins_w;
   logic [2:0] meta_q;
   logic [2:0] stab_q;
   logic [2:0] prev_q;

   assign pins_w = {serial_in, shift_clk, frame_sync_b};

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_sync
         localparam logic [2:0] IDLE_ALL = `PIN_IDLE;
         localparam logic       IDLE_BIT = IDLE_ALL[i];
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_q[i] <= IDLE_BIT;
               stab_q[i] <= IDLE_BIT;
               prev_q[i] <= IDLE_BIT;
            end else begin
               meta_q[i] <= pins_w[i];
               stab_q[i] <= meta_q[i];
               prev_q[i] <= stab_q[i];
            end
         end
      end
   endgenerate

   assign lk.sclk_fall  = prev_q[1] & ~stab_q[1];
   assign lk.frame_fall = prev_q[0] & ~stab_q[0];
   assign lk.frame_rise = ~prev_q[0] & stab_q[0];
   assign lk.frame_low  = ~stab_q[0];
   assign lk.data_bit   = stab_q[2];
endmodule
`default_nettype wire

// file: test/dac_cmd_sva.sv
// Concurrent checks on the ports of the serial command decoder.
`include "dac_defs.svh"
`default_nettype none
module dac_cmd_sva #(
   parameter int CHANNELS   = 8,
   parameter int CODE_WIDTH = 10
) (
   input wire logic                           clk,
   input wire logic                           rst_b,
   input wire logic                           frame_sync_b,
   input wire logic                           shift_clk,
   input wire logic                           chain_out,
   input wire logic [7:0]                     reg_addr,
   input wire logic                           reg_rd,
   input wire logic [31:0]                    reg_rdata,
   input wire logic [CHANNELS*CODE_WIDTH-1:0] out_codes,
   input wire logic [CHANNELS-1:0]            pd_mask,
   input wire logic [1:0]                     pd_term,
   input wire dac_pkg::op_mode_t              operating_mode
);
   import dac_pkg::*;
   logic [5:0] fall_cnt_q;
   logic [3:0] since_rise_q;
   logic       sclk_q;
   logic       sync_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fall_cnt_q   <= 6'h00;
         since_rise_q <= 4'hF;
         sclk_q       <= 1'b1;
         sync_q       <= 1'b1;
      end else begin
         sclk_q <= shift_clk;
         sync_q <= frame_sync_b;
         if (sync_q && !frame_sync_b) begin
            fall_cnt_q <= 6'h00;
         end else if (!frame_sync_b && sclk_q && !shift_clk && fall_cnt_q != 6'h3F) begin
            fall_cnt_q <= fall_cnt_q + 6'h01;
         end
         if (!sync_q && frame_sync_b) begin
            since_rise_q <= 4'h0;
         end else if (since_rise_q != 4'hF) begin
            since_rise_q <= since_rise_q + 4'h1;
         end
      end
   end
   exec_gate_a : assert property (
      $changed(out_codes) |-> since_rise_q <= 4'h8 && fall_cnt_q >= 6'h0F)
      else $error("output codes changed outside a completed frame");
   mode_gate_a : assert property (
      $changed(operating_mode) |-> since_rise_q <= 4'h8 && fall_cnt_q >= 6'h0F)
      else $error("mode changed outside a completed frame");
   pd_gate_a : assert property (
      $changed(pd_mask) |-> since_rise_q <= 4'h8 && fall_cnt_q >= 6'h0F)
      else $error("power-down flags changed outside a completed frame");
   term_code_a : assert property (
      $changed(pd_term) |-> pd_term != 2'h0 && since_rise_q <= 4'h8)
      else $error("termination changed to an illegal value");
   chain_start_a : assert property (
      $fell(frame_sync_b) |-> !chain_out [*8])
      else $error("chain output high at frame start");
   chain_late_a : assert property (
      chain_out |-> fall_cnt_q >= 6'h0F)
      else $error("chain output high before the fifteenth edge");
   status_read_a : assert property (
      reg_rd && reg_addr == `STATUS_OFF |=> reg_rdata[0] == $past(operating_mode)
         && reg_rdata[15:8] == $past(pd_mask) && reg_rdata[3:2] == $past(pd_term))
      else $error("status read disagrees with outputs");
   out_read_a : assert property (
      reg_rd && reg_addr == `OUT_BASE_OFF |=> reg_rdata[9:0] == $past(out_codes[9:0]))
      else $error("output code read disagrees with output");
endmodule
bind dac_cmd_decoder dac_cmd_sva #(.CHANNELS(CHANNELS), .CODE_WIDTH(CODE_WIDTH)) dac_cmd_sva_i (
   .clk(clk), .rst_b(rst_b), .frame_sync_b(frame_sync_b), .shift_clk(shift_clk), .chain_out(chain_out),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_codes(out_codes), .pd_mask(pd_mask),
   .pd_term(pd_term), .operating_mode(operating_mode));
`default_nettype wire

// file: test/host_model.sv
// Host that drives write frames on the serial link.
`default_nettype none
module host_model (
   input  wire logic clk,
   output var  logic frame_sync_b,
   output var  logic shift_clk,
   output var  logic serial_in,
   input  wire logic chain_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] seen;
   initial begin
      frame_sync_b = 1'b1;
      shift_clk = 1'b1;
      serial_in = 1'b0;
      seen = '0;
   end
   task automatic half();
      repeat (16) @(posedge clk);
   endtask
   task automatic send(input logic [63:0] w, input int n);
      @(posedge clk);
      frame_sync_b <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in <= w[i];
         half();
         seen[n - 1 - i] = chain_out;
         shift_clk <= 1'b0;
         half();
         shift_clk <= 1'b1;
      end
      half();
      seen[n] = chain_out;
      frame_sync_b <= 1'b1;
      serial_in <= ~w[0];
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench of the serial command decoder.
`default_nettype none
module tb_top;
   import dac_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_b, reg_wr, reg_rd, frame_sync_b, shift_clk, serial_in, chain_out, xmode;
   logic [7:0]  reg_addr, pd_mask, xmask;
   logic [31:0] reg_wdata, reg_rdata;
   logic [79:0] out_codes;
   logic [1:0]  pd_term, xterm;
   op_mode_t    operating_mode;
   logic [9:0]  dreg [8];
   logic [9:0]  oreg [8];
   int          errors, cmp_count, cycles;
   dac_cmd_decoder dac_cmd_decoder_i (.clk(clk), .rst_b(rst_b), .frame_sync_b(frame_sync_b),
      .shift_clk(shift_clk), .serial_in(serial_in), .chain_out(chain_out), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_codes(out_codes),
      .pd_mask(pd_mask), .pd_term(pd_term), .operating_mode(operating_mode));
   host_model host_model_i (.clk(clk), .frame_sync_b(frame_sync_b), .shift_clk(shift_clk),
      .serial_in(serial_in), .chain_out(chain_out));
   initial clk = 1'b0;
   always #2 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         test_done();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic load(input int k);
      oreg[k] = dreg[k];
      xmask[k] = 1'b0;
   endtask
   task automatic model_cmd(input logic [15:0] w);
      case (w[15:12])
         4'h8: xmode = 1'b0;
         4'h9: xmode = 1'b1;
         4'hA: for (int k = 0; k < 8; k++) if (w[k]) load(k);
         4'hB: begin
            dreg[0] = w[11:2];
            for (int k = 0; k < 8; k++) load(k);
         end
         4'hC: for (int k = 0; k < 8; k++) begin
            dreg[k] = w[11:2];
            load(k);
         end
         4'hD, 4'hE, 4'hF: begin
            xmask = xmask | w[7:0];
            xterm = w[13:12];
         end
         default: begin
            dreg[w[14:12]] = w[11:2];
            if (xmode) load(int'(w[14:12]));
         end
      endcase
   endtask
   task automatic cmd(input logic [15:0] w);
      host_model_i.send({48'h0, w}, 16);
      model_cmd(w);
   endtask
   task automatic check_all();
      logic [31:0] d;
      for (int k = 0; k < 8; k++) begin
         rd(8'(8'h10 + 4 * k), d);
         check(32'(d[9:0]), 32'(dreg[k]));
         rd(8'(8'h30 + 4 * k), d);
         check(32'(d[9:0]), 32'(oreg[k]));
         check(32'(out_codes[10*k +: 10]), 32'(oreg[k]));
      end
      check(32'(operating_mode), 32'(xmode));
      check(32'(pd_mask), 32'(xmask));
      check(32'(pd_term), 32'(xterm));
   endtask
   task automatic t_reset();
      logic [31:0] d;
      check_all();
      rd(8'h04, d);
      check(32'(d[0]), 32'h0);
      rd(8'hFC, d);
      check(d, 32'h0);
   endtask
   task automatic t_modes();
      cmd(16'h2ABF);
      check_all();
      cmd(16'h9000);
      cmd(16'h5FFC);
      check_all();
      cmd(16'h8000);
      cmd(16'h7123);
      check_all();
   endtask
   task automatic t_special();
      cmd(16'h1C00);
      cmd(16'h3400);
      cmd(16'hA00A);
      check_all();
      cmd(16'h9000);
      cmd(16'hB7FC);
      check_all();
      cmd(16'hC554);
      check_all();
      cmd(16'h8000);
      cmd(16'hA0FF);
      check_all();
   endtask
   task automatic t_power();
      logic [7:0] m [3] = '{8'h81, 8'h3C, 8'h42};
      for (int i = 0; i < 3; i++) begin
         cmd({4'(4'hD + i), 4'h0, m[i]});
         check_all();
      end
      cmd(16'hA0FF);
      check_all();
   endtask
   task automatic t_abort();
      host_model_i.send({50'h0, 14'h30FF}, 14);
      check_all();
   endtask
   // Two-word chained frame; the chain output feeds back to the host.
   task automatic t_chain();
      logic [15:0] w1 = 16'h6A5C;
      host_model_i.send({32'h0, w1, 16'hC2A8}, 32);
      model_cmd(16'hC2A8);
      for (int i = 1; i < 15; i++) check(32'(host_model_i.seen[i]), 32'h0);
      check(32'(host_model_i.seen[15]), 32'h1);
      for (int i = 16; i < 32; i++) check(32'(host_model_i.seen[i]), 32'(w1[31-i]));
      check_all();
   endtask
   task automatic t_regs();
      logic [31:0] d;
      wr(8'h00, 32'h0);
      host_model_i.send({48'h0, 16'hCFFC}, 16);
      wr(8'h10, 32'h3FF);
      wr(8'hFC, 32'hFFFF);
      check_all();
      rd(8'h08, d);
      check(d, 32'h0000_0012);
      rd(8'h0C, d);
      check(d, 32'h0000_0001);
      wr(8'h00, 32'h1);
      rd(8'h00, d);
      check(32'(d[0]), 32'h1);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      errors = 0;
      cmp_count = 0;
      cycles = 0;
      xmode = 1'b0;
      xmask = '0;
      xterm = '0;
      foreach (dreg[k]) dreg[k] = '0;
      foreach (oreg[k]) oreg[k] = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      t_reset();
      t_modes();
      t_special();
      t_power();
      t_abort();
      t_chain();
      t_regs();
      test_done();
   end
endmodule
`default_nettype wire
